//--- rtl/timer_pair_pkg.sv
// Purpose: Constants for the dual timer/counter block
// Assumes: 8-bit register port, one core clock
// Notes: Register offsets are byte addresses on the register port
package timer_pair_pkg;
   localparam logic [7:0] ctrl_off = 8'h88;
   localparam logic [7:0] mode_off = 8'h89;
   localparam logic [7:0] c0_low_off = 8'h8A;
   localparam logic [7:0] c1_low_off = 8'h8B;
   localparam logic [7:0] c0_high_off = 8'h8C;
   localparam logic [7:0] c1_high_off = 8'h8D;
   localparam logic [7:0] irq_stat_off = 8'h90;
   localparam logic [7:0] irq_mask_off = 8'h91;
   localparam logic [7:0] isr_ack_off = 8'h92;
   localparam logic [7:0] ctrl_rst = 8'h00;
   localparam logic [7:0] mode_rst = 8'h00;
   localparam logic [7:0] byte_rst = 8'h00;
   localparam int ctrl_tf1_pos = 7;
   localparam int ctrl_tr1_pos = 6;
   localparam int ctrl_tf0_pos = 5;
   localparam int ctrl_tr0_pos = 4;
   localparam int mode_gate_pos = 3;
   localparam int mode_ct_pos = 2;
   localparam int mode_field_w = 4;
   localparam int tick_div = 6;
   localparam logic [2:0] tick_last = 3'(tick_div - 1);
   localparam logic [1:0] mode_13bit = 2'h0;
   localparam logic [1:0] mode_16bit = 2'h1;
   localparam logic [1:0] mode_reload = 2'h2;
   localparam logic [1:0] mode_split = 2'h3;
   localparam logic [4:0] presc_max = 5'h1F;
   localparam logic [7:0] byte_max = 8'hFF;
endpackage

//--- rtl/dual_timer_counter.sv
// Purpose: Two timer/counter channels with mode and control registers
// Assumes: Pins asynchronous; register port with one-cycle read data
// Notes: Lower control nibble stored as plain read/write bits
`timescale 1ns/1ps
module dual_timer_counter
   import timer_pair_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic count_pin0,
   input wire logic count_pin1,
   input wire logic ext_irq0_pin,
   input wire logic ext_irq1_pin,
   input wire logic isr_enter0,
   input wire logic isr_enter1,
   output logic irq_out
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [2:0] sync_t0_ff, sync_t1_ff, sync_i0_ff, sync_i1_ff;
   logic t0_lvl_ff, t1_lvl_ff, i0_lvl_ff, i1_lvl_ff;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         {sync_t0_ff, sync_t1_ff, sync_i0_ff, sync_i1_ff} <= 12'h000;
      else
      begin
         sync_t0_ff <= {sync_t0_ff[1:0], count_pin0};
         sync_t1_ff <= {sync_t1_ff[1:0], count_pin1};
         sync_i0_ff <= {sync_i0_ff[1:0], ext_irq0_pin};
         sync_i1_ff <= {sync_i1_ff[1:0], ext_irq1_pin};
      end
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         {t0_lvl_ff, t1_lvl_ff, i0_lvl_ff, i1_lvl_ff} <= 4'h0;
      else
      begin
         t0_lvl_ff <= (sync_t0_ff[1] == sync_t0_ff[2]) ? sync_t0_ff[2] : t0_lvl_ff;
         t1_lvl_ff <= (sync_t1_ff[1] == sync_t1_ff[2]) ? sync_t1_ff[2] : t1_lvl_ff;
         i0_lvl_ff <= (sync_i0_ff[1] == sync_i0_ff[2]) ? sync_i0_ff[2] : i0_lvl_ff;
         i1_lvl_ff <= (sync_i1_ff[1] == sync_i1_ff[2]) ? sync_i1_ff[2] : i1_lvl_ff;
      end
   end

   // ----------------------------------------
   // Tick divider and pin sampling
   // ----------------------------------------
   logic [2:0] div_ff;
   logic tick;
   logic smp0_ff, smp1_ff;
   logic edge0, edge1;
   assign tick = (div_ff == tick_last);
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_ff <= 3'h0;
      else if (tick)
         div_ff <= 3'h0;
      else
         div_ff <= div_ff + 3'h1;
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         {smp0_ff, smp1_ff} <= 2'h0;
      else if (tick)
      begin
         smp0_ff <= t0_lvl_ff;
         smp1_ff <= t1_lvl_ff;
      end
   end
   assign edge0 = tick && smp0_ff && !t0_lvl_ff;
   assign edge1 = tick && smp1_ff && !t1_lvl_ff;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] mode_ff, ctrl_ff;
   logic [7:0] c0_low_ff, c0_high_ff, c1_low_ff, c1_high_ff;
   logic [1:0] stat_ff, mask_ff;
   logic [3:0] m0f, m1f;
   logic wr_ctrl, wr_mode, wr_ack;
   assign m0f = mode_ff[mode_field_w-1:0];
   assign m1f = mode_ff[2*mode_field_w-1:mode_field_w];
   assign wr_ctrl = reg_wr && (reg_addr == ctrl_off);
   assign wr_mode = reg_wr && (reg_addr == mode_off);
   assign wr_ack = reg_wr && (reg_addr == isr_ack_off);
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_ff <= mode_rst;
      else if (wr_mode)
         mode_ff <= reg_wdata;
   end

   // ----------------------------------------
   // Count enables
   // ----------------------------------------
   logic run0, run1, gate0, gate1, src0, src1;
   logic inc0, inc1, inc0h;
   logic [1:0] md0, md1;
   assign md0 = m0f[1:0];
   assign md1 = m1f[1:0];
   assign src0 = m0f[mode_ct_pos] ? edge0 : tick;
   assign src1 = m1f[mode_ct_pos] ? edge1 : tick;
   assign gate0 = ctrl_ff[ctrl_tr0_pos] && (!m0f[mode_gate_pos] || i0_lvl_ff);
   assign gate1 = m1f[mode_gate_pos] ? i1_lvl_ff : 1'b1;
   assign run0 = gate0;
   // TR1 belongs to channel 0 high byte in split mode; run1 then follows gate1 alone
   assign run1 = (md0 == mode_split) ? gate1 : (ctrl_ff[ctrl_tr1_pos] && gate1);
   assign inc0 = run0 && src0;
   // Channel 1 halts in mode 3
   assign inc1 = run1 && src1 && (md1 != mode_split);
   // High-byte timer counts ticks whenever the TR1 control bit is set, ungated
   assign inc0h = (md0 == mode_split) && ctrl_ff[ctrl_tr1_pos] && tick;

   // ----------------------------------------
   // Channel 0 count
   // ----------------------------------------
   logic ovf0, ovf0h, ovf1;
   logic [7:0] nxt_c0_low, nxt_c0_high, nxt_c1_low, nxt_c1_high;
   always_comb
   begin
      nxt_c0_low = c0_low_ff;
      nxt_c0_high = c0_high_ff;
      ovf0 = 1'b0;
      ovf0h = 1'b0;
      if (inc0)
      begin
         case (md0)
            mode_13bit:
            begin
               nxt_c0_low = {c0_low_ff[7:5], c0_low_ff[4:0] + 5'h1};
               if (c0_low_ff[4:0] == presc_max)
               begin
                  nxt_c0_high = c0_high_ff + 8'h1;
                  ovf0 = (c0_high_ff == byte_max);
               end
            end
            mode_16bit:
            begin
               nxt_c0_low = c0_low_ff + 8'h1;
               if (c0_low_ff == byte_max)
               begin
                  nxt_c0_high = c0_high_ff + 8'h1;
                  ovf0 = (c0_high_ff == byte_max);
               end
            end
            mode_reload:
            begin
               if (c0_low_ff == byte_max)
               begin
                  nxt_c0_low = c0_high_ff;
                  ovf0 = 1'b1;
               end
               else
                  nxt_c0_low = c0_low_ff + 8'h1;
            end
            default:
            begin
               nxt_c0_low = c0_low_ff + 8'h1;
               ovf0 = (c0_low_ff == byte_max);
            end
         endcase
      end
      if (inc0h)
      begin
         nxt_c0_high = c0_high_ff + 8'h1;
         ovf0h = (c0_high_ff == byte_max);
      end
   end

   // ----------------------------------------
   // Channel 1 count
   // ----------------------------------------
   always_comb
   begin
      nxt_c1_low = c1_low_ff;
      nxt_c1_high = c1_high_ff;
      ovf1 = 1'b0;
      if (inc1)
      begin
         case (md1)
            mode_13bit:
            begin
               nxt_c1_low = {c1_low_ff[7:5], c1_low_ff[4:0] + 5'h1};
               if (c1_low_ff[4:0] == presc_max)
               begin
                  nxt_c1_high = c1_high_ff + 8'h1;
                  ovf1 = (c1_high_ff == byte_max);
               end
            end
            mode_16bit:
            begin
               nxt_c1_low = c1_low_ff + 8'h1;
               if (c1_low_ff == byte_max)
               begin
                  nxt_c1_high = c1_high_ff + 8'h1;
                  ovf1 = (c1_high_ff == byte_max);
               end
            end
            mode_reload:
            begin
               if (c1_low_ff == byte_max)
               begin
                  nxt_c1_low = c1_high_ff;
                  ovf1 = 1'b1;
               end
               else
                  nxt_c1_low = c1_low_ff + 8'h1;
            end
            default: nxt_c1_low = c1_low_ff;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         {c0_low_ff, c0_high_ff, c1_low_ff, c1_high_ff} <= {4{byte_rst}};
      else
      begin
         c0_low_ff <= (reg_wr && reg_addr == c0_low_off) ? reg_wdata : nxt_c0_low;
         c0_high_ff <= (reg_wr && reg_addr == c0_high_off) ? reg_wdata : nxt_c0_high;
         c1_low_ff <= (reg_wr && reg_addr == c1_low_off) ? reg_wdata : nxt_c1_low;
         c1_high_ff <= (reg_wr && reg_addr == c1_high_off) ? reg_wdata : nxt_c1_high;
      end
   end

   // ----------------------------------------
   // Control register and flags
   // ----------------------------------------
   logic set0, set1, clr0, clr1;
   logic nxt_tf0, nxt_tf1;
   assign set0 = ovf0;
   // Split high byte takes over flag 1
   assign set1 = (md0 == mode_split) ? ovf0h : ovf1;
   assign clr0 = isr_enter0 || (wr_ack && reg_wdata[0]);
   assign clr1 = isr_enter1 || (wr_ack && reg_wdata[1]);
   // Set beats clear; software write otherwise
   always_comb
   begin
      nxt_tf0 = ctrl_ff[ctrl_tf0_pos];
      nxt_tf1 = ctrl_ff[ctrl_tf1_pos];
      if (wr_ctrl)
      begin
         nxt_tf0 = reg_wdata[ctrl_tf0_pos];
         nxt_tf1 = reg_wdata[ctrl_tf1_pos];
      end
      if (clr0 && !wr_ctrl)
         nxt_tf0 = 1'b0;
      if (clr1 && !wr_ctrl)
         nxt_tf1 = 1'b0;
      if (set0)
         nxt_tf0 = 1'b1;
      if (set1)
         nxt_tf1 = 1'b1;
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_ff <= ctrl_rst;
      else
      begin
         ctrl_ff[ctrl_tf1_pos] <= nxt_tf1;
         ctrl_ff[ctrl_tf0_pos] <= nxt_tf0;
         if (wr_ctrl)
         begin
            ctrl_ff[ctrl_tr1_pos] <= reg_wdata[ctrl_tr1_pos];
            ctrl_ff[ctrl_tr0_pos] <= reg_wdata[ctrl_tr0_pos];
            ctrl_ff[3:0] <= reg_wdata[3:0];
         end
      end
   end

   // ----------------------------------------
   // Interrupt status, mask and output
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         {stat_ff, mask_ff, irq_out} <= 5'h00;
      else
      begin
         if (reg_wr && reg_addr == irq_stat_off)
            stat_ff <= (stat_ff & ~reg_wdata[1:0]) | {set1, set0};
         else
            stat_ff <= stat_ff | {set1, set0};
         if (reg_wr && reg_addr == irq_mask_off)
            mask_ff <= reg_wdata[1:0];
         irq_out <= |(stat_ff & mask_ff);
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            ctrl_off: reg_rdata <= ctrl_ff;
            mode_off: reg_rdata <= mode_ff;
            c0_low_off: reg_rdata <= c0_low_ff;
            c1_low_off: reg_rdata <= c1_low_ff;
            c0_high_off: reg_rdata <= c0_high_ff;
            c1_high_off: reg_rdata <= c1_high_ff;
            irq_stat_off: reg_rdata <= {6'h00, stat_ff};
            irq_mask_off: reg_rdata <= {6'h00, mask_ff};
            default: reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_tick_period: assert property (@(posedge core_clk) disable iff (!rst_n)
      tick |=> !tick [*5] ##1 tick)
      else $error("tick period not six");
   a_halt_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!ctrl_ff[ctrl_tr0_pos] && md0 != mode_split && !reg_wr)
      |=> $stable(c0_low_ff) && $stable(c0_high_ff))
      else $error("halted channel 0 changed");
   a_ovf0_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
      set0 |=> ctrl_ff[ctrl_tf0_pos])
      else $error("overflow flag 0 not set");
   a_reload_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
      (inc0 && md0 == mode_reload && c0_low_ff == byte_max && !reg_wr)
      |=> c0_low_ff == $past(c0_high_ff) && $stable(c0_high_ff))
      else $error("reload failed");
   a_ch1_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
      (md1 == mode_split && !reg_wr) |=> $stable(c1_low_ff) && $stable(c1_high_ff))
      else $error("channel 1 counted in mode 3");
   a_gate0_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
      (m0f[mode_gate_pos] && !i0_lvl_ff) |-> !inc0)
      else $error("gated channel 0 counted");
   a_gate1_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
      (m1f[mode_gate_pos] && !i1_lvl_ff) |-> !inc1)
      else $error("gated channel 1 counted");
   a_wrap13: assert property (@(posedge core_clk) disable iff (!rst_n)
      (inc0 && md0 == mode_13bit && c0_low_ff[4:0] == presc_max && c0_high_ff == byte_max)
      |-> set0)
      else $error("13-bit wrap missed");
   a_edge_count: assert property (@(posedge core_clk) disable iff (!rst_n)
      (m0f[mode_ct_pos] && inc0) |-> (smp0_ff && !t0_lvl_ff && tick))
      else $error("count without falling edge");
endmodule

//--- verification/pin_partner.sv
// Purpose: Far-side pins: count pins, gate pins, service entry
// Assumes: Count pins idle high, gate pins start low
// Notes: Each count edge lasts two ticks per level
`timescale 1ns/1ps
module pin_partner
(
   input wire logic core_clk,
   output logic count_pin0,
   output logic count_pin1,
   output logic ext_irq0_pin,
   output logic ext_irq1_pin,
   output logic isr_enter0,
   output logic isr_enter1
);
   initial
   begin
      count_pin0 = 1'b1;
      count_pin1 = 1'b1;
      ext_irq0_pin = 1'b0;
      ext_irq1_pin = 1'b0;
      isr_enter0 = 1'b0;
      isr_enter1 = 1'b0;
   end

   task automatic pulse(input int ch, input int n);
      repeat (n)
      begin
         repeat (12) @(posedge core_clk);
         if (ch == 0) count_pin0 <= 1'b0;
         else count_pin1 <= 1'b0;
         repeat (12) @(posedge core_clk);
         count_pin0 <= 1'b1;
         count_pin1 <= 1'b1;
      end
   endtask

   task automatic gate(input logic g0, input logic g1);
      ext_irq0_pin <= g0;
      ext_irq1_pin <= g1;
   endtask

   task automatic isr(input int ch);
      if (ch == 0) isr_enter0 <= 1'b1;
      else isr_enter1 <= 1'b1;
      @(posedge core_clk);
      isr_enter0 <= 1'b0;
      isr_enter1 <= 1'b0;
   endtask
endmodule

//--- verification/dual_timer_counter_test.sv
// Purpose: Self-checking bench for the dual timer/counter
// Assumes: Register port with one-cycle read data
// Notes: Run windows are sixty clocks, so exactly ten ticks
`timescale 1ns/1ps
module dual_timer_counter_test;
   import timer_pair_pkg::*;
   logic core_clk, rst_n, reg_wr, reg_rd, irq_out;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic cp0, cp1, gp0, gp1, ie0, ie1;
   int miscompares, num_checks;

   // ----------------------------------------
   // Instances
   // ----------------------------------------
   dual_timer_counter DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .count_pin0(cp0), .count_pin1(cp1), .ext_irq0_pin(gp0), .ext_irq1_pin(gp1),
      .isr_enter0(ie0), .isr_enter1(ie1), .irq_out(irq_out));
   pin_partner pins (.core_clk(core_clk), .count_pin0(cp0), .count_pin1(cp1),
      .ext_irq0_pin(gp0), .ext_irq1_pin(gp1), .isr_enter0(ie0), .isr_enter1(ie1));

   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic close_out;
      if (miscompares == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
      @(posedge core_clk);
   endtask

   task automatic irq_is(input logic exp);
      @(negedge core_clk);
      check({7'h00, irq_out}, {7'h00, exp});
      @(posedge core_clk);
   endtask

   task automatic run(input logic [7:0] a, input logic [7:0] go, input logic [7:0] stop);
      wr(a, go);
      repeat (58) @(posedge core_clk);
      wr(a, stop);
   endtask

   task automatic load(input logic [7:0] l0, h0, l1, h1);
      wr(c0_low_off, l0);
      wr(c0_high_off, h0);
      wr(c1_low_off, l1);
      wr(c1_high_off, h1);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic s_reset;
      logic [7:0] offs [8] = '{ctrl_off, mode_off, c0_low_off, c1_low_off,
         c0_high_off, c1_high_off, irq_stat_off, irq_mask_off};
      foreach (offs[i]) rdc(offs[i], 8'h00);
      wr(8'h87, 8'hA5);
      rdc(8'h87, 8'h00);
      wr(mode_off, 8'hA5);
      rdc(mode_off, 8'hA5);
   endtask

   task automatic s_mode1;
      wr(mode_off, 8'h11);
      load(8'hFB, 8'hFF, 8'hF8, 8'h00);
      run(ctrl_off, 8'h50, 8'h20);
      rdc(c0_low_off, 8'h05);
      rdc(c0_high_off, 8'h00);
      rdc(c1_low_off, 8'h02);
      rdc(c1_high_off, 8'h01);
      rdc(ctrl_off, 8'h20);
      rdc(c1_low_off, 8'h02);
      rdc(irq_stat_off, 8'h01);
      irq_is(1'b0);
      wr(irq_mask_off, 8'h03);
      irq_is(1'b1);
      wr(irq_stat_off, 8'h01);
      irq_is(1'b0);
      pins.isr(0);
      rdc(ctrl_off, 8'h00);
      wr(ctrl_off, 8'h80);
      rdc(ctrl_off, 8'h80);
      pins.isr(1);
      rdc(ctrl_off, 8'h00);
      wr(ctrl_off, 8'hA0);
      wr(isr_ack_off, 8'h01);
      rdc(ctrl_off, 8'h80);
      wr(isr_ack_off, 8'h02);
      rdc(ctrl_off, 8'h00);
      rdc(isr_ack_off, 8'h00);
   endtask

   task automatic s_mode0;
      wr(mode_off, 8'h00);
      load(8'hFB, 8'hFF, 8'h1E, 8'h00);
      run(ctrl_off, 8'h50, 8'h20);
      rdc(c0_low_off, 8'hE5);
      rdc(c0_high_off, 8'h00);
      rdc(c1_low_off, 8'h08);
      rdc(c1_high_off, 8'h01);
      rdc(irq_stat_off, 8'h01);
      irq_is(1'b1);
      wr(irq_stat_off, 8'h03);
      irq_is(1'b0);
   endtask

   task automatic s_mode2;
      wr(mode_off, 8'h22);
      load(8'hFC, 8'hF0, 8'h00, 8'h80);
      run(ctrl_off, 8'h50, 8'h20);
      rdc(c0_low_off, 8'hF6);
      rdc(c0_high_off, 8'hF0);
      rdc(c1_low_off, 8'h0A);
      rdc(irq_stat_off, 8'h01);
      wr(irq_mask_off, 8'h02);
      irq_is(1'b0);
      wr(irq_mask_off, 8'h03);
      wr(irq_stat_off, 8'h03);
   endtask

   task automatic s_mode3;
      wr(mode_off, 8'h33);
      load(8'h10, 8'hFA, 8'h30, 8'h00);
      run(ctrl_off, 8'h50, 8'h80);
      rdc(c0_low_off, 8'h1A);
      rdc(c0_high_off, 8'h04);
      rdc(c1_low_off, 8'h30);
      rdc(irq_stat_off, 8'h02);
      irq_is(1'b1);
      wr(irq_stat_off, 8'h03);
      irq_is(1'b0);
      wr(ctrl_off, 8'h00);
      run(mode_off, 8'h13, 8'h33);
      rdc(c1_low_off, 8'h3A);
      rdc(c0_low_off, 8'h1A);
   endtask

   task automatic s_gate;
      wr(mode_off, 8'h99);
      load(8'h00, 8'h00, 8'h00, 8'h00);
      run(ctrl_off, 8'h50, 8'h00);
      rdc(c0_low_off, 8'h00);
      rdc(c1_low_off, 8'h00);
      pins.gate(1'b1, 1'b1);
      repeat (8) @(posedge core_clk);
      run(ctrl_off, 8'h50, 8'h00);
      rdc(c0_low_off, 8'h0A);
      rdc(c1_low_off, 8'h0A);
      pins.gate(1'b0, 1'b0);
   endtask

   task automatic s_counter;
      wr(mode_off, 8'h55);
      load(8'h00, 8'h00, 8'h00, 8'h00);
      wr(ctrl_off, 8'h50);
      pins.pulse(0, 3);
      pins.pulse(1, 5);
      repeat (20) @(posedge core_clk);
      wr(ctrl_off, 8'h00);
      rdc(c0_low_off, 8'h03);
      rdc(c1_low_off, 8'h05);
   endtask

   task automatic s_rst2;
      wr(ctrl_off, 8'h5A);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rdc(ctrl_off, 8'h00);
      rdc(mode_off, 8'h00);
      rdc(c0_low_off, 8'h00);
      rdc(c1_low_off, 8'h00);
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      close_out();
   end

   initial
   begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      s_reset();
      s_mode1();
      s_mode0();
      s_mode2();
      s_mode3();
      s_gate();
      s_counter();
      s_rst2();
      close_out();
   end
endmodule
